// ### shared/atx_pkg.sv
// Shared constants for the serial transmitter/receiver block
package atx_pkg;
  // Register word indexes (byte address = index * 4)
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_LCTL = 3'h1;
  localparam logic [2:0] REG_LSTS = 3'h2;
  localparam logic [2:0] REG_DIVL = 3'h3;
  localparam logic [2:0] REG_DIVH = 3'h4;
  localparam int         ADDR_W   = 5;
  // Line control fields
  localparam int LC_WLEN_LO = 0;
  localparam int LC_WLEN_HI = 1;
  localparam int LC_STOP    = 2;
  localparam int LC_PAR_EN  = 3;
  localparam int LC_PAR_EVN = 4;
  // Line status fields
  localparam int LS_DREADY  = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARERR  = 2;
  localparam int LS_FRAMERR = 3;
  localparam int LS_HOLD_MT = 5;
  localparam int LS_ALL_MT  = 6;
  // Reset values
  localparam logic [7:0]  LCTL_RST = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  localparam logic [7:0]  LS_CLR_MASK = 8'h0e;
  // Timing in 16x ticks; WLEN_BASE is the word length minus one for length code 0
  localparam logic [5:0] TICKS_BIT  = 6'h10;
  localparam logic [5:0] TICKS_1P5  = 6'h18;
  localparam logic [5:0] TICKS_2    = 6'h20;
  localparam logic [3:0] RX_MID     = 4'h7;
  localparam logic [3:0] RX_LAST    = 4'hf;
  localparam logic [2:0] WLEN_BASE  = 3'h4;
  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } atx_tx_state_t;
  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } atx_rx_state_t;
endpackage

// ### rtl/atx_uart.sv
// Serial transmitter/receiver with rate divider and Avalon-MM registers
`timescale 1ns/1ns
module atx_uart #(
  parameter logic [15:0] DIV_RESET = atx_pkg::DIV_RST
) (
  input  wire logic                      I_CLK_SYS,
  input  wire logic                      I_RST_B,
  input  wire logic [atx_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
  input  wire logic                      I_AVS_READ,
  input  wire logic                      I_AVS_WRITE,
  input  wire logic [31:0]               I_AVS_WRITEDATA,
  input  wire logic [3:0]                I_AVS_BYTEENABLE,
  output logic      [31:0]               O_AVS_READDATA,
  output logic                           O_AVS_WAITREQUEST,
  input  wire logic                      I_SERIAL_IN,
  output logic                           O_SERIAL_OUT,
  output logic                           O_RATE_CLOCK_OUT
);
  if (DIV_RESET == 16'h0000)
  begin : g_chk
    $error("DIV_RESET must be nonzero");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: one wait cycle, answer on second cycle
  logic        ack_reg, ack_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [7:0]  rx_buffer_reg;
  logic [7:0]  line_control_reg, line_control_next;
  logic [15:0] divisor_reg, divisor_next;
  logic [2:0]  widx;
  logic        req, accept, wr_data, rd_data, rd_lsts;
  logic [7:0]  line_status;

  assign widx   = I_AVS_ADDRESS[atx_pkg::ADDR_W-1:2];
  assign req    = I_AVS_READ | I_AVS_WRITE;
  assign accept = req & ack_reg;
  assign O_AVS_WAITREQUEST = req & ~ack_reg;
  assign O_AVS_READDATA    = {24'h000000, rdata_reg};
  assign wr_data = accept & I_AVS_WRITE & I_AVS_BYTEENABLE[0] &
                   (widx == atx_pkg::REG_DATA);
  assign rd_data = accept & I_AVS_READ & (widx == atx_pkg::REG_DATA);
  assign rd_lsts = accept & I_AVS_READ & (widx == atx_pkg::REG_LSTS);

  always_comb
  begin
    ack_next          = req & ~ack_reg;
    rdata_next        = rdata_reg;
    line_control_next = line_control_reg;
    divisor_next      = divisor_reg;
    if (req & ~ack_reg & I_AVS_READ)
    begin
      case (widx)
        atx_pkg::REG_DATA: rdata_next = rx_buffer_reg;
        atx_pkg::REG_LCTL: rdata_next = line_control_reg;
        atx_pkg::REG_LSTS: rdata_next = line_status;
        atx_pkg::REG_DIVL: rdata_next = divisor_reg[7:0];
        atx_pkg::REG_DIVH: rdata_next = divisor_reg[15:8];
        default:           rdata_next = 8'h00;
      endcase
    end
    if (accept & I_AVS_WRITE & I_AVS_BYTEENABLE[0])
    begin
      case (widx)
        atx_pkg::REG_LCTL: line_control_next = I_AVS_WRITEDATA[7:0];
        atx_pkg::REG_DIVL: divisor_next[7:0] = I_AVS_WRITEDATA[7:0];
        atx_pkg::REG_DIVH: divisor_next[15:8] = I_AVS_WRITEDATA[7:0];
        default:           divisor_next = divisor_reg;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      ack_reg          <= 1'b0;
      rdata_reg        <= 8'h00;
      line_control_reg <= atx_pkg::LCTL_RST;
      divisor_reg      <= DIV_RESET;
    end
    else
    begin
      ack_reg          <= ack_next;
      rdata_reg        <= rdata_next;
      line_control_reg <= line_control_next;
      divisor_reg      <= divisor_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate divider; divisor 0 behaves as 65536
  logic [15:0] div_cnt_reg, div_cnt_next;
  logic        tick, rate_reg;
  logic [2:0]  wlen_m1;
  logic [5:0]  stop_len;

  assign tick = (div_cnt_reg == 16'h0000);
  assign O_RATE_CLOCK_OUT = rate_reg;
  // Character shape from line control; word length shared by both directions, stop length used by the transmitter only
  assign wlen_m1 = atx_pkg::WLEN_BASE +
                   {1'b0, line_control_reg[atx_pkg::LC_WLEN_HI:
                                           atx_pkg::LC_WLEN_LO]};
  assign stop_len = !line_control_reg[atx_pkg::LC_STOP] ? atx_pkg::TICKS_BIT :
                    (wlen_m1 == atx_pkg::WLEN_BASE) ? atx_pkg::TICKS_1P5 :
                    atx_pkg::TICKS_2;

  always_comb
  begin
    div_cnt_next = tick ? divisor_reg - 16'h0001
                        : div_cnt_reg - 16'h0001;
  end

  // Block clock is the oscillator; flopped tick is the 16x output
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      div_cnt_reg <= 16'h0000;
      rate_reg    <= 1'b0;
    end
    else
    begin
      div_cnt_reg <= div_cnt_next;
      rate_reg    <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  atx_pkg::atx_tx_state_t tx_state_reg, tx_state_next;
  logic [7:0] tx_holding_buffer_reg, tx_holding_buffer_next;
  logic [7:0] tx_shift_register_reg, tx_shift_register_next;
  logic       tx_holding_empty_flag_reg, tx_holding_empty_flag_next;
  logic       tx_all_empty_flag_reg, tx_all_empty_flag_next;
  logic       tx_par_reg, tx_par_next, tx_line_reg, tx_line_next;
  logic [5:0] tx_cnt_reg, tx_cnt_next;
  logic [2:0] tx_idx_reg, tx_idx_next;
  logic [5:0] tx_len;
  logic [7:0] tx_mask;

  assign O_SERIAL_OUT = tx_line_reg;
  assign tx_len  = (tx_state_reg == atx_pkg::TX_STOP) ? stop_len
                                                      : atx_pkg::TICKS_BIT;
  assign tx_mask = 8'hff >> (3'h7 - wlen_m1);

  always_comb
  begin
    tx_state_next              = tx_state_reg;
    tx_holding_buffer_next     = tx_holding_buffer_reg;
    tx_shift_register_next     = tx_shift_register_reg;
    tx_holding_empty_flag_next = tx_holding_empty_flag_reg;
    tx_all_empty_flag_next     = tx_all_empty_flag_reg;
    tx_par_next                = tx_par_reg;
    tx_cnt_next                = tx_cnt_reg;
    tx_idx_next                = tx_idx_reg;
    case (tx_state_reg)
      atx_pkg::TX_IDLE:
      begin
        if (!tx_holding_empty_flag_reg)
        begin
          tx_shift_register_next     = tx_holding_buffer_reg;
          tx_par_next                = ^(tx_holding_buffer_reg & tx_mask) ^
                                      ~line_control_reg[atx_pkg::LC_PAR_EVN];
          tx_holding_empty_flag_next = 1'b1;
          tx_all_empty_flag_next     = 1'b0;
          tx_cnt_next                = 6'h00;
          tx_state_next              = atx_pkg::TX_START;
        end
      end
      default:
      begin
        if (tick)
        begin
          tx_cnt_next = tx_cnt_reg + 6'h01;
          if (tx_cnt_next == tx_len)
          begin
            tx_cnt_next = 6'h00;
            case (tx_state_reg)
              atx_pkg::TX_START:
              begin
                tx_idx_next   = 3'h0;
                tx_state_next = atx_pkg::TX_DATA;
              end
              atx_pkg::TX_DATA:
              begin
                tx_shift_register_next = tx_shift_register_reg >> 1;
                tx_idx_next            = tx_idx_reg + 3'h1;
                if (tx_idx_reg == wlen_m1)
                begin
                  tx_state_next = line_control_reg[atx_pkg::LC_PAR_EN] ?
                                  atx_pkg::TX_PAR : atx_pkg::TX_STOP;
                end
              end
              atx_pkg::TX_PAR:
              begin
                tx_state_next = atx_pkg::TX_STOP;
              end
              default:
              begin
                // A waiting word keeps all-empty low across the gap
                tx_all_empty_flag_next = tx_holding_empty_flag_reg;
                tx_state_next          = atx_pkg::TX_IDLE;
              end
            endcase
          end
        end
      end
    endcase
    // Host write wins over a load in the same cycle
    if (wr_data)
    begin
      tx_holding_buffer_next     = I_AVS_WRITEDATA[7:0];
      tx_holding_empty_flag_next = 1'b0;
    end
    case (tx_state_next)
      atx_pkg::TX_START: tx_line_next = 1'b0;
      atx_pkg::TX_DATA:  tx_line_next = tx_shift_register_next[0];
      atx_pkg::TX_PAR:   tx_line_next = tx_par_next;
      default:           tx_line_next = 1'b1;
    endcase
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      tx_state_reg              <= atx_pkg::TX_IDLE;
      tx_holding_buffer_reg     <= 8'h00;
      tx_shift_register_reg     <= 8'h00;
      tx_holding_empty_flag_reg <= 1'b1;
      tx_all_empty_flag_reg     <= 1'b1;
      tx_par_reg                <= 1'b0;
      tx_line_reg               <= 1'b1;
      tx_cnt_reg                <= 6'h00;
      tx_idx_reg                <= 3'h0;
    end
    else
    begin
      tx_state_reg              <= tx_state_next;
      tx_holding_buffer_reg     <= tx_holding_buffer_next;
      tx_shift_register_reg     <= tx_shift_register_next;
      tx_holding_empty_flag_reg <= tx_holding_empty_flag_next;
      tx_all_empty_flag_reg     <= tx_all_empty_flag_next;
      tx_par_reg                <= tx_par_next;
      tx_line_reg               <= tx_line_next;
      tx_cnt_reg                <= tx_cnt_next;
      tx_idx_reg                <= tx_idx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  atx_pkg::atx_rx_state_t rx_state_reg, rx_state_next;
  logic [7:0] rx_shift_register_reg, rx_shift_register_next;
  logic [7:0] rx_buffer_next, rx_word;
  logic [3:0] rx_cnt_reg, rx_cnt_next;
  logic [2:0] rx_idx_reg, rx_idx_next;
  logic       rx_prev_reg, rx_pbit_reg, rx_pbit_next, rx_xfer;
  logic       dr_reg, dr_next, oe_reg, oe_next;
  logic       pe_reg, pe_next, fe_reg, fe_next;
  logic       ls_clr;

  assign rx_word = rx_shift_register_reg >> (3'h7 - wlen_m1);

  always_comb
  begin
    line_status                      = 8'h00;
    line_status[atx_pkg::LS_DREADY]  = dr_reg;
    line_status[atx_pkg::LS_OVERRUN] = oe_reg;
    line_status[atx_pkg::LS_PARERR]  = pe_reg;
    line_status[atx_pkg::LS_FRAMERR] = fe_reg;
    line_status[atx_pkg::LS_HOLD_MT] = tx_holding_empty_flag_reg;
    line_status[atx_pkg::LS_ALL_MT]  = tx_all_empty_flag_reg;
  end
  // Only error bits the host actually saw are cleared
  assign ls_clr = rd_lsts;

  always_comb
  begin
    rx_state_next          = rx_state_reg;
    rx_shift_register_next = rx_shift_register_reg;
    rx_buffer_next         = rx_buffer_reg;
    rx_cnt_next            = rx_cnt_reg;
    rx_idx_next            = rx_idx_reg;
    rx_pbit_next           = rx_pbit_reg;
    rx_xfer                = 1'b0;
    dr_next = dr_reg & ~rd_data;
    oe_next = oe_reg & ~(ls_clr & rdata_reg[atx_pkg::LS_OVERRUN]);
    pe_next = pe_reg & ~(ls_clr & rdata_reg[atx_pkg::LS_PARERR]);
    fe_next = fe_reg & ~(ls_clr & rdata_reg[atx_pkg::LS_FRAMERR]);
    case (rx_state_reg)
      atx_pkg::RX_IDLE:
      begin
        if (rx_prev_reg & ~I_SERIAL_IN)
        begin
          rx_cnt_next   = 4'h0;
          rx_state_next = atx_pkg::RX_START;
        end
      end
      atx_pkg::RX_START:
      begin
        if (tick)
        begin
          rx_cnt_next = rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == atx_pkg::RX_MID)
          begin
            rx_cnt_next   = 4'h0;
            rx_idx_next   = 3'h0;
            rx_state_next = I_SERIAL_IN ? atx_pkg::RX_IDLE
                                        : atx_pkg::RX_DATA;
          end
        end
      end
      default:
      begin
        if (tick)
        begin
          rx_cnt_next = rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == atx_pkg::RX_LAST)
          begin
            case (rx_state_reg)
              atx_pkg::RX_DATA:
              begin
                rx_shift_register_next = {I_SERIAL_IN,
                                          rx_shift_register_reg[7:1]};
                rx_idx_next = rx_idx_reg + 3'h1;
                if (rx_idx_reg == wlen_m1)
                begin
                  rx_state_next = line_control_reg[atx_pkg::LC_PAR_EN] ?
                                  atx_pkg::RX_PAR : atx_pkg::RX_STOP;
                end
              end
              atx_pkg::RX_PAR:
              begin
                rx_pbit_next  = I_SERIAL_IN;
                rx_state_next = atx_pkg::RX_STOP;
              end
              default:
              begin
                // Only the first stop bit is checked
                rx_xfer        = 1'b1;
                rx_buffer_next = rx_word;
                dr_next        = 1'b1;
                if (dr_reg & ~rd_data)
                begin
                  oe_next = 1'b1;
                end
                if (line_control_reg[atx_pkg::LC_PAR_EN] &
                    (^rx_word ^ rx_pbit_reg ^
                     line_control_reg[atx_pkg::LC_PAR_EVN]) == 1'b0)
                begin
                  pe_next = 1'b1;
                end
                if (!I_SERIAL_IN)
                begin
                  fe_next = 1'b1;
                end
                rx_state_next = atx_pkg::RX_IDLE;
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      rx_state_reg          <= atx_pkg::RX_IDLE;
      rx_shift_register_reg <= 8'h00;
      rx_buffer_reg         <= 8'h00;
      rx_cnt_reg            <= 4'h0;
      rx_idx_reg            <= 3'h0;
      rx_prev_reg           <= 1'b1;
      rx_pbit_reg           <= 1'b0;
      dr_reg                <= 1'b0;
      oe_reg                <= 1'b0;
      pe_reg                <= 1'b0;
      fe_reg                <= 1'b0;
    end
    else
    begin
      rx_state_reg          <= rx_state_next;
      rx_shift_register_reg <= rx_shift_register_next;
      rx_buffer_reg         <= rx_buffer_next;
      rx_cnt_reg            <= rx_cnt_next;
      rx_idx_reg            <= rx_idx_next;
      rx_prev_reg           <= I_SERIAL_IN;
      rx_pbit_reg           <= rx_pbit_next;
      dr_reg                <= dr_next;
      oe_reg                <= oe_next;
      pe_reg                <= pe_next;
      fe_reg                <= fe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);

  sequence s_tx_load;
    (tx_state_reg == atx_pkg::TX_IDLE) && !tx_holding_empty_flag_reg;
  endsequence
  sequence s_rx_noise;
    (rx_state_reg == atx_pkg::RX_START) && tick &&
    (rx_cnt_reg == atx_pkg::RX_MID) && I_SERIAL_IN;
  endsequence

  property p_wr_clears_hold;
    wr_data |=> !tx_holding_empty_flag_reg;
  endproperty
  a_wr_clears_hold: assert property (p_wr_clears_hold)
    else $error("holding-empty not cleared by write");

  property p_load;
    s_tx_load ##0 !wr_data |=> tx_holding_empty_flag_reg &&
                  !tx_all_empty_flag_reg && !O_SERIAL_OUT;
  endproperty
  a_load: assert property (p_load)
    else $error("load to shifter wrong");

  property p_busy_not_empty;
    (tx_state_reg != atx_pkg::TX_IDLE) |-> !tx_all_empty_flag_reg;
  endproperty
  a_busy_not_empty: assert property (p_busy_not_empty)
    else $error("all-empty high while shifting");

  property p_start_low;
    (tx_state_reg == atx_pkg::TX_START) |-> !O_SERIAL_OUT;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");

  property p_dr_set;
    rx_xfer |=> dr_reg && (rx_buffer_reg == $past(rx_word));
  endproperty
  a_dr_set: assert property (p_dr_set)
    else $error("data-ready not set on transfer");

  property p_dr_clr;
    rd_data && !rx_xfer |=> !dr_reg;
  endproperty
  a_dr_clr: assert property (p_dr_clr)
    else $error("data-ready not cleared by read");

  property p_overrun;
    rx_xfer && dr_reg && !rd_data |=> oe_reg;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_div_one;
    (divisor_reg == 16'h0001)[*2] |-> tick;
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("divisor one does not tick every cycle");

  property p_noise;
    s_rx_noise |=> (rx_state_reg == atx_pkg::RX_IDLE) && !rx_xfer;
  endproperty
  a_noise: assert property (p_noise)
    else $error("noise start bit not discarded");

  property p_bus_answer;
    req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("waitrequest held more than one cycle");
endmodule

// ### sim/atx_line_model.sv
// Remote serial line partner: drives frames in, collects frames out
`timescale 1ns/1ns
module atx_line_model (
  input  wire logic        i_clk,
  input  wire logic        i_txd,
  input  wire logic [15:0] i_div,
  input  wire logic [3:0]  i_nbits,
  output logic             o_rxd
);
  logic [11:0] got_q[$];
  initial o_rxd = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // Start low, data LSB first, parity, stop high; line idles high after
  task automatic send(input logic [11:0] b, input int n, input int len);
    @(posedge i_clk);
    for (int k = 0; k < n; k++)
    begin
      o_rxd <= b[k];
      repeat (len) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
    repeat (16 * i_div) @(posedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Mid-bit sampling; only start..first stop kept, later stops ignored
  always
  begin : rx_collect
    logic [11:0] w;
    @(negedge i_txd);
    w = 12'h000;
    repeat (8 * i_div) @(posedge i_clk);
    for (int k = 0; k < i_nbits; k++)
    begin
      w[k] = i_txd;
      if (k + 1 < i_nbits)
        repeat (16 * i_div) @(posedge i_clk);
    end
    got_q.push_back(w);
  end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the serial transmitter/receiver
`timescale 1ns/1ns
module tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  be = 4'h1;
  logic [31:0] rdata;
  logic        wait_r;
  logic        serial_in;
  logic        sout;
  logic        rate;
  logic [15:0] div = 16'h0001;
  logic [3:0]  nbits = 4'h7;
  int          miscompares = 0;
  int          checks = 0;
  int          cyc = 0;
  int          seed = 83;
  logic [7:0]  line_control;
  logic [7:0]  d;
  logic [7:0]  st;
  logic [11:0] fb;
  always #50 clk = ~clk;
  atx_uart atx_uart_i (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
    .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wait_r), .I_SERIAL_IN(serial_in), .O_SERIAL_OUT(sout),
    .O_RATE_CLOCK_OUT(rate));
  atx_line_model atx_line_model_i (.i_clk(clk), .i_txd(sout), .i_div(div),
    .i_nbits(nbits), .o_rxd(serial_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // Request held until waitrequest seen low at a rising edge
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] v,
                     input logic [3:0] b, output logic [7:0] r);
    @(posedge clk);
    addr <= {a, 2'b00};
    wr <= w;
    rd <= !w;
    wdata <= {24'h000000, v};
    be <= b;
    // Only the bench timeout may end this wait
    do
    begin
      @(posedge clk);
    end
    while (wait_r !== 1'b0);
    r = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wr8(input logic [2:0] a, input logic [7:0] v);
    logic [7:0] r;
    bus(1'b1, a, v, 4'h1, r);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, 4'h1, r);
    chk({4'h0, r}, {4'h0, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////
  function automatic int wlen(input logic [7:0] c);
    return int'(c[1:0]) + 5;
  endfunction
  function automatic int nb(input logic [7:0] c);
    return wlen(c) + 2 + int'(c[3]);
  endfunction
  function automatic logic [7:0] dmask(input logic [7:0] c);
    return 8'hff >> (8 - wlen(c));
  endfunction
  function automatic logic [11:0] frame(input logic [7:0] c,
                                        input logic [7:0] v);
    logic [11:0] f;
    f = 12'hffe;
    for (int k = 0; k < wlen(c); k++)
      f[k + 1] = v[k];
    if (c[3])
      f[wlen(c) + 1] = (^(v & dmask(c))) ^ !c[4];
    return f & ~(12'hfff << nb(c));
  endfunction
  task automatic wait_frame(input logic [11:0] exp);
    int n;
    n = 0;
    while (atx_line_model_i.got_q.size() == 0 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    chk(atx_line_model_i.got_q.pop_front(), exp);
  endtask
  // Rate output counted over 30 clocks; exact for divisors 1 and 3
  task automatic rate_chk(input int exp);
    int cnt;
    cnt = 0;
    repeat (30)
    begin
      @(posedge clk);
      cnt += int'(rate);
    end
    chk(12'(cnt), 12'(exp));
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      $display("MISMATCH %0t timeout", $time);
      miscompares++;
      end_of_test;
    end
  end
  initial
  begin
    logic [7:0]  x;
    logic [7:0]  e;
    logic [15:0] dv;
    int          n;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rchk(atx_pkg::REG_LSTS, 8'h60);
    rchk(atx_pkg::REG_DIVL, 8'h01);
    rchk(3'h5, 8'h00);
    bus(1'b1, atx_pkg::REG_LSTS, 8'hff, 4'h1, x);
    bus(1'b1, atx_pkg::REG_LCTL, 8'h1f, 4'h0, x);
    rchk(atx_pkg::REG_LSTS, 8'h60);
    rchk(atx_pkg::REG_LCTL, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      dv = (p == 0) ? 16'h0001 : 16'h0003;
      wr8(atx_pkg::REG_DIVL, dv[7:0]);
      wr8(atx_pkg::REG_DIVH, 8'h00);
      div <= dv;
      rate_chk(30 / int'(dv));
      for (int i = 0; i < 8; i++)
      begin
        line_control = {3'h0, 3'($random(seed)), 2'(i)};
        nbits <= 4'(nb(line_control));
        wr8(atx_pkg::REG_LCTL, line_control);
        rchk(atx_pkg::REG_LCTL, line_control);
        d = 8'($random(seed));
        e = 8'($random(seed));
        wr8(atx_pkg::REG_DATA, d);
        wr8(atx_pkg::REG_DATA, e);
        rchk(atx_pkg::REG_LSTS, 8'h00);
        wait_frame(frame(line_control, d));
        repeat (40 * dv) @(posedge clk);
        rchk(atx_pkg::REG_LSTS, 8'h20);
        wait_frame(frame(line_control, e));
        repeat (32 * dv) @(posedge clk);
        rchk(atx_pkg::REG_LSTS, 8'h60);
      end
      // Cases cycle: clean, parity error, framing error, overrun
      for (int i = 0; i < 8; i++)
      begin
        line_control = {3'h0, 3'($random(seed)), 2'($random(seed))};
        if (i % 4 == 1)
          line_control[3] = 1'b1;
        wr8(atx_pkg::REG_LCTL, line_control);
        d = 8'($random(seed));
        fb = frame(line_control, d);
        n = nb(line_control);
        st = 8'h61;
        if (i % 4 == 1)
        begin
          fb[wlen(line_control) + 1] = !fb[wlen(line_control) + 1];
          st = 8'h65;
        end
        if (i % 4 == 2)
        begin
          fb[n - 1] = 1'b0;
          st = 8'h69;
        end
        if (i % 4 == 3)
        begin
          atx_line_model_i.send(frame(line_control, ~d), n, 16 * dv);
          st = 8'h63;
        end
        atx_line_model_i.send(fb, n, 16 * dv);
        rchk(atx_pkg::REG_LSTS, st);
        rchk(atx_pkg::REG_DATA, d & dmask(line_control));
        rchk(atx_pkg::REG_LSTS, 8'h60);
      end
    end
    // Low glitch shorter than half a bit must not start a character
    atx_line_model_i.send(12'h000, 1, 5 * dv);
    rchk(atx_pkg::REG_LSTS, 8'h60);
    end_of_test;
  end
endmodule
